// ==== include/card_seq_pkg.sv ====
// Constants, field layouts and types for the card session sequencer
package card_seq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int T_NS = 25000;
    localparam int T_CYC = T_NS * CLK_MHZ / 1000;
    localparam int OSC_PER_T = 64;
    localparam int HALF_T_OSC = OSC_PER_T / 2;
    localparam logic [7:0] OSC_HI_DIV = 8'(T_CYC / OSC_PER_T);
    localparam logic [7:0] OSC_LO_DIV = 8'h48;
    localparam int CLK_GAP_NS = 200;
    localparam int CLK_GAP_CYC = (CLK_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int DEBOUNCE_MS = 8;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
    localparam int OC_FILTER_US = 10;
    localparam int OC_FILTER_CYC = OC_FILTER_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Sequencer steps in half-T units
    // ------------------------------------------------------------
    localparam logic [4:0] ACT_T1 = 5'h01;
    localparam logic [4:0] ACT_RAMP = ACT_T1 + 5'h03;
    localparam logic [4:0] ACT_IO = ACT_T1 + 5'h08;
    localparam logic [4:0] ACT_RST = ACT_T1 + 5'h0e;
    localparam logic [4:0] DE_CLK = 5'h01;
    localparam logic [4:0] DE_IO = 5'h02;
    localparam logic [4:0] DE_FALL = 5'h03;
    localparam logic [4:0] DE_PUMP = 5'h0a;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int APB_AW = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_FAULT = 12'h008;
    localparam int CTRL_HI_LSB = 0;
    localparam int CTRL_LO_LSB = 8;
    localparam int STS_STATE_LSB = 0;
    localparam int STS_PRESENT = 2;
    localparam int STS_OSC_HIGH = 3;
    localparam int STS_CLK_RUN = 4;
    localparam int FLT_OC = 0;
    localparam int FLT_RM = 1;
    localparam int FLT_LS = 2;
    localparam int FLT_PUMP = 3;
    localparam int FLT_HOT = 4;
    localparam int FLT_W = 5;

    // Card clock divider select codes {hi, lo}
    localparam logic [1:0] SEL_DIV8 = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] SEL_DIV2 = 2'h3;
    localparam logic [1:0] SEL_DIV1 = 2'h2;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ACT = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_DEACT = 2'b11
    } seq_state_t;

    typedef enum logic [1:0]
    {
        IDX_CTRL = 2'b00,
        IDX_STATUS = 2'b01,
        IDX_FAULT = 2'b10,
        IDX_NONE = 2'b11
    } reg_idx_t;

endpackage

// ==== hw/card_session_sequencer.sv ====
// Card session sequencer: activation, deactivation, faults, APB registers
`timescale 1ns/1ps

// Function
// - Idle: presence output shows card present
// - Session start switches oscillator to high
// - Doubler on, supply ramp done t1+1.5T
// - Data lines low, released at t1+4T
// - Card reset low until t1+7T, then follows
// - Reset high at start: clock on fall
// - After t5 reset no clock influence
// - Reset low at start: clock t3+200ns
// - Deactivate: reset, clock, supply fall order
// - Data lines low at t10+T
// - Pump off, contacts grounded t10+5T
// - After deactivation oscillator back to low
// - Monitor five fault sources
// - Idle supply drop pulses internal reset
// - Session fault drops output, deactivates
// - Insertion debounced about 8 ms
// - Removal deactivates at once, output low
// - Filtered supply overload detection
// - Reset state is inactive mode
// - Card clock divide select, glitch free
module card_session_sequencer
#(
    parameter int DEBOUNCE_CYC = card_seq_pkg::DEBOUNCE_CYC,
    parameter int OC_FILTER_CYC = card_seq_pkg::OC_FILTER_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic session_request_n,
    input wire logic host_reset_in,
    input wire logic card_detect,
    input wire logic card_detect_n,
    input wire logic divider_select_hi,
    input wire logic divider_select_lo,
    input wire logic crystal_input,
    input wire logic vcc_overcurrent,
    input wire logic logic_supply_low,
    input wire logic pump_fault,
    input wire logic overheat,
    output logic fault_presence,
    output logic pump_output,
    output logic card_supply_en,
    output logic vcc_ramp_done,
    output logic card_reset,
    output logic card_clk,
    output logic [2:0] card_data_en,
    output logic contacts_grounded,
    output logic osc_high,
    output logic por_pulse
);

    localparam int DEB_W = $clog2(DEBOUNCE_CYC + 1);
    localparam int OC_W = $clog2(OC_FILTER_CYC + 1);

    typedef struct packed
    {
        card_seq_pkg::seq_state_t state;
        logic [4:0] step;
        logic [7:0] tick_cnt;
        logic [4:0] osc_cnt;
        logic [7:0] hi_div;
        logic [7:0] lo_div;
        logic osc_high;
        logic pump_on;
        logic supply_en;
        logic ramp_done;
        logic [2:0] data_en;
        logic card_reset;
        logic clk_run;
        logic card_clk;
        logic [1:0] div_cnt;
        logic [1:0] cur_sel;
        logic xtal_q;
        logic rst_at_t0;
        logic [2:0] gap_cnt;
        logic sess_q;
        logic present;
        logic [DEB_W-1:0] deb_cnt;
        logic [OC_W-1:0] oc_cnt;
        logic fault_presence;
        logic [card_seq_pkg::FLT_W-1:0] fault_sts;
        logic contacts_grounded;
        logic lsl_q;
        logic por_pulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } seq_regs_t;

    // Inactive mode after reset
    localparam seq_regs_t RST_VAL = '{
        state: card_seq_pkg::ST_IDLE,
        hi_div: card_seq_pkg::OSC_HI_DIV,
        lo_div: card_seq_pkg::OSC_LO_DIV,
        contacts_grounded: 1'b1,
        sess_q: 1'b1,
        default: '0
    };

    seq_regs_t r;
    seq_regs_t n;

    // Address to register index
    function automatic card_seq_pkg::reg_idx_t reg_idx(input logic [11:0] a);
        case (a)
            card_seq_pkg::REG_CTRL: reg_idx = card_seq_pkg::IDX_CTRL;
            card_seq_pkg::REG_STATUS: reg_idx = card_seq_pkg::IDX_STATUS;
            card_seq_pkg::REG_FAULT: reg_idx = card_seq_pkg::IDX_FAULT;
            default: reg_idx = card_seq_pkg::IDX_NONE;
        endcase
    endfunction

    // Crystal edges per card clock half period, less one (last div_cnt value)
    function automatic logic [1:0] half_last(input logic [1:0] sel);
        case (sel)
            card_seq_pkg::SEL_DIV8: half_last = 2'h3;
            card_seq_pkg::SEL_DIV4: half_last = 2'h1;
            default: half_last = 2'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic tick;
        logic half_step;
        logic xtal_rise;
        logic raw_present;
        logic in_session;
        logic fault_now;
        logic oc_trip;
        logic wr_en;
        logic [4:0] step_n;
        logic [7:0] div;
        logic [1:0] new_sel;
        logic [card_seq_pkg::FLT_W-1:0] flt_now;
        logic [card_seq_pkg::FLT_W-1:0] clr;
        card_seq_pkg::reg_idx_t idx;
        tick = 1'b0;
        half_step = 1'b0;
        xtal_rise = 1'b0;
        raw_present = 1'b0;
        in_session = 1'b0;
        fault_now = 1'b0;
        oc_trip = 1'b0;
        wr_en = 1'b0;
        step_n = '0;
        div = '0;
        new_sel = '0;
        flt_now = '0;
        clr = '0;
        idx = reg_idx(paddr);
        n = r;

        // APB slave, one wait state
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (psel && penable && !r.pready)
        begin
            n.pready = 1'b1;
            n.pslverr = (idx == card_seq_pkg::IDX_NONE);
            n.prdata = '0;
            if (!pwrite)
            begin
                case (idx)
                    card_seq_pkg::IDX_CTRL:
                        n.prdata = {16'h0000, r.lo_div, r.hi_div};
                    card_seq_pkg::IDX_STATUS:
                        n.prdata = {27'h0000000, r.clk_run, r.osc_high,
                            r.present, r.state};
                    card_seq_pkg::IDX_FAULT:
                        n.prdata = {27'h0000000, r.fault_sts};
                    default:
                        n.prdata = '0;
                endcase
            end
        end
        wr_en = psel && penable && r.pready && pwrite;
        if (wr_en && idx == card_seq_pkg::IDX_CTRL)
        begin
            n.hi_div = pwdata[card_seq_pkg::CTRL_HI_LSB +: 8];
            n.lo_div = pwdata[card_seq_pkg::CTRL_LO_LSB +: 8];
        end
        if (wr_en && idx == card_seq_pkg::IDX_FAULT)
        begin
            clr = pwdata[card_seq_pkg::FLT_W-1:0];
        end

        // Internal oscillator, 32 periods make one half T
        div = r.osc_high ? r.hi_div : r.lo_div;
        tick = ({1'b0, r.tick_cnt} + 9'h001 >= {1'b0, div});
        n.tick_cnt = tick ? 8'h00 : r.tick_cnt + 8'h01;
        n.osc_cnt = tick ? r.osc_cnt + 5'h01 : r.osc_cnt;
        half_step = tick &&
            (r.osc_cnt == 5'(card_seq_pkg::HALF_T_OSC - 1));
        step_n = r.step + {4'h0, half_step};

        // Presence: slow on insertion, instant on removal
        raw_present = card_detect || !card_detect_n;
        if (!raw_present)
        begin
            n.present = 1'b0;
            n.deb_cnt = '0;
            n.fault_presence = 1'b0;
        end
        else if (!r.present)
        begin
            if (r.deb_cnt == DEB_W'(DEBOUNCE_CYC - 1))
            begin
                n.present = 1'b1;
            end
            n.deb_cnt = r.deb_cnt + 1'b1;
        end

        // Supply overload must persist to trip
        if (!vcc_overcurrent)
        begin
            n.oc_cnt = '0;
        end
        else if (r.oc_cnt != OC_W'(OC_FILTER_CYC - 1))
        begin
            n.oc_cnt = r.oc_cnt + 1'b1;
        end
        oc_trip = vcc_overcurrent &&
            (r.oc_cnt == OC_W'(OC_FILTER_CYC - 1));

        // Fault sources
        flt_now[card_seq_pkg::FLT_OC] = oc_trip;
        flt_now[card_seq_pkg::FLT_RM] = !raw_present;
        flt_now[card_seq_pkg::FLT_LS] = logic_supply_low;
        flt_now[card_seq_pkg::FLT_PUMP] = pump_fault;
        flt_now[card_seq_pkg::FLT_HOT] = overheat;
        in_session = (r.state == card_seq_pkg::ST_ACT) ||
            (r.state == card_seq_pkg::ST_ACTIVE);
        fault_now = in_session && (|flt_now);
        n.fault_sts = (r.fault_sts & ~clr) | (fault_now ? flt_now : '0);

        // Supply drop outside a session pulses internal reset
        n.lsl_q = logic_supply_low;
        n.por_pulse = !in_session && logic_supply_low && !r.lsl_q;
        n.sess_q = session_request_n;

        // Session sequencer
        case (r.state)
            card_seq_pkg::ST_IDLE:
            begin
                n.fault_presence = r.present && raw_present;
                if (r.sess_q && !session_request_n && r.present &&
                    raw_present)
                begin
                    n.state = card_seq_pkg::ST_ACT;
                    n.osc_high = 1'b1;
                    n.pump_on = 1'b1;
                    n.contacts_grounded = 1'b0;
                    n.step = '0;
                    n.tick_cnt = '0;
                    n.osc_cnt = '0;
                    n.gap_cnt = '0;
                    n.rst_at_t0 = host_reset_in;
                end
            end
            card_seq_pkg::ST_ACT:
            begin
                n.step = step_n;
                n.card_reset = 1'b0;
                if (step_n >= card_seq_pkg::ACT_T1)
                begin
                    n.supply_en = 1'b1;
                end
                if (step_n >= card_seq_pkg::ACT_RAMP)
                begin
                    n.ramp_done = 1'b1;
                end
                if (step_n >= card_seq_pkg::ACT_IO)
                begin
                    n.data_en = 3'h7;
                end
                if (!r.clk_run && r.rst_at_t0)
                begin
                    if (r.step >= card_seq_pkg::ACT_IO && !host_reset_in)
                    begin
                        n.clk_run = 1'b1;
                    end
                end
                else if (!r.clk_run && r.data_en[0])
                begin
                    n.gap_cnt = r.gap_cnt + 3'h1;
                    if (r.gap_cnt == 3'(card_seq_pkg::CLK_GAP_CYC - 1))
                    begin
                        n.clk_run = 1'b1;
                    end
                end
                if (step_n == card_seq_pkg::ACT_RST)
                begin
                    n.state = card_seq_pkg::ST_ACTIVE;
                    n.clk_run = 1'b1;
                    n.card_reset = host_reset_in;
                end
            end
            card_seq_pkg::ST_ACTIVE:
            begin
                n.card_reset = host_reset_in;
            end
            card_seq_pkg::ST_DEACT:
            begin
                n.step = step_n;
                n.card_reset = 1'b0;
                if (step_n >= card_seq_pkg::DE_CLK)
                begin
                    n.clk_run = 1'b0;
                end
                if (step_n >= card_seq_pkg::DE_IO)
                begin
                    n.data_en = 3'h0;
                end
                if (step_n >= card_seq_pkg::DE_FALL)
                begin
                    n.supply_en = 1'b0;
                    n.ramp_done = 1'b0;
                end
                if (step_n == card_seq_pkg::DE_PUMP)
                begin
                    n.pump_on = 1'b0;
                    n.contacts_grounded = 1'b1;
                    n.osc_high = 1'b0;
                    n.state = card_seq_pkg::ST_IDLE;
                end
            end
            default:
            begin
                n.state = card_seq_pkg::ST_IDLE;
            end
        endcase

        // Host release or fault counts the sequencer back
        if (in_session && (session_request_n || fault_now))
        begin
            n.state = card_seq_pkg::ST_DEACT;
            n.step = '0;
            n.tick_cnt = '0;
            n.osc_cnt = '0;
            n.card_reset = 1'b0;
            if (fault_now)
            begin
                n.fault_presence = 1'b0;
            end
        end

        // Card clock from crystal, select changes only while low
        xtal_rise = crystal_input && !r.xtal_q;
        n.xtal_q = crystal_input;
        new_sel = {divider_select_hi, divider_select_lo};
        if (!n.clk_run)
        begin
            n.card_clk = 1'b0;
            n.div_cnt = '0;
            n.cur_sel = new_sel;
        end
        else if (r.cur_sel == card_seq_pkg::SEL_DIV1)
        begin
            // Rises only on a crystal edge, so no short pulse on entry
            n.card_clk = crystal_input && (r.card_clk || xtal_rise);
            if (!crystal_input && !r.card_clk)
            begin
                n.cur_sel = new_sel;
            end
        end
        else if (xtal_rise)
        begin
            if (r.div_cnt == half_last(r.cur_sel))
            begin
                n.card_clk = !r.card_clk;
                n.div_cnt = '0;
                if (r.card_clk)
                begin
                    n.cur_sel = new_sel;
                end
            end
            else
            begin
                n.div_cnt = r.div_cnt + 2'h1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= RST_VAL;
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign fault_presence = r.fault_presence;
    assign pump_output = r.pump_on;
    assign card_supply_en = r.supply_en;
    assign vcc_ramp_done = r.ramp_done;
    assign card_reset = r.card_reset;
    assign card_clk = r.card_clk;
    assign card_data_en = r.data_en;
    assign contacts_grounded = r.contacts_grounded;
    assign osc_high = r.osc_high;
    assign por_pulse = r.por_pulse;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Fault condition as seen by the checks
    logic fault_now_chk;
    assign fault_now_chk = (r.state == card_seq_pkg::ST_ACT ||
        r.state == card_seq_pkg::ST_ACTIVE) && (vcc_overcurrent &&
        r.oc_cnt == OC_W'(OC_FILTER_CYC - 1) || pump_fault || overheat ||
        logic_supply_low || !(card_detect || !card_detect_n));

    sequence in_sess_s;
        r.state == card_seq_pkg::ST_ACT || r.state == card_seq_pkg::ST_ACTIVE;
    endsequence
    sequence deact_entry;
        in_sess_s ##1 (r.state == card_seq_pkg::ST_DEACT && r.step == 5'h00);
    endsequence

    AST_IDLE_PRESENCE: assert property (
        r.state == card_seq_pkg::ST_IDLE && r.present && card_detect
        |=> fault_presence)
        else $error("presence not shown while idle");
    AST_OSC_HIGH: assert property (
        r.state == card_seq_pkg::ST_ACT |-> osc_high)
        else $error("oscillator low during activation");
    AST_RAMP_STEP: assert property (
        $rose(vcc_ramp_done) |-> r.step == card_seq_pkg::ACT_RAMP &&
        card_supply_en && pump_output)
        else $error("supply ramp done at wrong step");
    AST_DATA_RELEASE: assert property (
        $rose(card_data_en[0]) |-> r.step == card_seq_pkg::ACT_IO &&
        !card_reset)
        else $error("data lines released at wrong step");
    AST_RESET_HELD: assert property (
        r.state == card_seq_pkg::ST_ACT |-> !card_reset)
        else $error("card reset high during activation");
    AST_RESET_FOLLOW: assert property (
        r.state == card_seq_pkg::ST_ACTIVE && !session_request_n &&
        !fault_now_chk |=> card_reset == $past(host_reset_in))
        else $error("card reset does not follow host reset");
    AST_DEACT_ORDER: assert property (
        deact_entry |-> !card_reset ##1 (!card_reset)[*8])
        else $error("card reset not low in deactivation");
    AST_CLK_LOW: assert property (
        r.state == card_seq_pkg::ST_DEACT &&
        r.step >= card_seq_pkg::DE_CLK |-> !card_clk)
        else $error("card clock running after hold point");
    AST_DATA_LOW: assert property (
        r.state == card_seq_pkg::ST_DEACT &&
        r.step >= card_seq_pkg::DE_IO |-> card_data_en == 3'h0)
        else $error("data lines not low in deactivation");
    AST_END_DEACT: assert property (
        r.state == card_seq_pkg::ST_DEACT ##1
        r.state == card_seq_pkg::ST_IDLE |-> !osc_high && !pump_output &&
        contacts_grounded)
        else $error("deactivation end state wrong");
    AST_FAULT_DEACT: assert property (
        fault_now_chk |=> !fault_presence &&
        r.state == card_seq_pkg::ST_DEACT)
        else $error("fault did not start deactivation");
    AST_REMOVAL: assert property (
        !card_detect && card_detect_n |=> !fault_presence)
        else $error("removal did not drop presence");

endmodule

// ==== verification/host_model.sv ====
// Host controller model driving session request and host reset
`timescale 1ns/1ps
module host_model
(
    input wire logic pclk,
    input wire logic card_present,
    output logic session_request_n = 1'h1,
    output logic host_reset_in = 1'h0
);
    // Session start, only with a card reported
    task automatic start(input logic rst_hi);
        wait (card_present === 1'h1);
        @(posedge pclk);
        host_reset_in <= rst_hi;
        session_request_n <= 1'h0;
    endtask
    // Reset change; raised only once the walk is past t5
    task automatic set_rst(input logic v);
        @(posedge pclk);
        host_reset_in <= v;
    endtask
    // Session end, also the answer to a fault
    task automatic stop();
        @(posedge pclk);
        session_request_n <= 1'h1;
    endtask
endmodule

// ==== verification/card_session_sequencer_test.sv ====
// Self-checking bench for the card session sequencer
`timescale 1ns/1ps
module card_session_sequencer_test;
    localparam int H = card_seq_pkg::HALF_T_OSC * 9;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, card_detect = 1'h0, crystal_input = 1'h0;
    logic overheat = 1'h0, vcc_overcurrent = 1'h0, logic_supply_low = 1'h0;
    logic divider_select_hi = 1'h0, divider_select_lo = 1'h0, err, clk_last;
    logic pump_fault = 1'h0, card_detect_n = 1'h1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h0643;
    logic pready, pslverr, session_request_n, host_reset_in, fault_presence;
    logic pump_output, card_supply_en, vcc_ramp_done, card_reset, card_clk;
    logic contacts_grounded, osc_high, por_pulse;
    logic [2:0] card_data_en;
    int fail_count = 0, total_checks = 0, cycles = 0, toggles = 0, pors = 0;
    int n;

    card_session_sequencer #(.DEBOUNCE_CYC(20), .OC_FILTER_CYC(4)) i_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .session_request_n, .host_reset_in, .card_detect,
        .card_detect_n, .divider_select_hi, .divider_select_lo,
        .crystal_input, .vcc_overcurrent, .logic_supply_low,
        .pump_fault, .overheat, .fault_presence, .pump_output,
        .card_supply_en, .vcc_ramp_done, .card_reset, .card_clk,
        .card_data_en, .contacts_grounded, .osc_high, .por_pulse
    );
    host_model i_host
    (
        .pclk, .card_present(fault_presence), .session_request_n,
        .host_reset_in
    );

    // Clock, crystal and run monitors
    initial forever #20 pclk = ~pclk;
    always
    begin
        repeat (3) @(posedge pclk);
        crystal_input <= ~crystal_input;
    end
    always @(posedge pclk)
    begin
        cycles++;
        toggles += (card_clk !== clk_last);
        clk_last = card_clk;
        pors += (por_pulse === 1'h1);
        if (cycles == 60000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Model of the card side per half-T step
    function automatic logic [7:0] pins();
        return {pump_output, card_supply_en, vcc_ramp_done, card_data_en,
            card_reset, osc_high};
    endfunction
    function automatic logic [7:0] act_exp(input int k);
        return {1'h1, k >= 1, k >= 4, (k >= 9) ? 3'h7 : 3'h0, 1'h0, 1'h1};
    endfunction
    function automatic logic [7:0] de_exp(input int k);
        return {k < 10, k < 3, k < 3, (k < 2) ? 3'h7 : 3'h0, 1'h0, k < 10};
    endfunction
    task automatic activate(input logic rst_hi);
        i_host.start(rst_hi);
        @(posedge pclk);
        toggles = 0;
        for (int k = 0; k < 16; k++)
        begin
            repeat (k == 0 ? H / 2 : H) @(posedge pclk);
            check(pins(), act_exp(k));
            check(toggles > 0, k >= (rst_hi ? 11 : 9));
            toggles = 0;
            if (rst_hi && k == 10)
                i_host.set_rst(1'h0);
        end
        i_host.set_rst(1'h1);
        repeat (3) @(posedge pclk);
        check(card_reset, 1'h1);
        $display("test activation done");
    endtask
    task automatic deact(input logic fp_end);
        for (int k = 0; k < 12; k++)
        begin
            repeat (k == 0 ? H / 2 : H) @(posedge pclk);
            check(pins(), de_exp(k));
            check({card_clk & (k >= 1), contacts_grounded}, k >= 10);
        end
        check(fault_presence, fp_end);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        check({pins(), contacts_grounded, fault_presence}, 10'h2);
        presetn <= 1'h1;
        apb(1'h0, card_seq_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h4809);
        lf = lfsr(lf);
        apb(1'h1, card_seq_pkg::REG_CTRL, lf);
        apb(1'h0, card_seq_pkg::REG_CTRL, 32'h0);
        check(rd, lf & 32'hffff);
        apb(1'h1, card_seq_pkg::REG_CTRL, 32'h4809);
        apb(1'h1, card_seq_pkg::REG_STATUS, lf);
        apb(1'h0, card_seq_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h00c, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        $display("test registers done");
        card_detect <= 1'h1;
        repeat (5) @(posedge pclk);
        check(fault_presence, 1'h0);
        repeat (40) @(posedge pclk);
        check(fault_presence, 1'h1);
        n = pors;
        logic_supply_low <= 1'h1;
        repeat (4) @(posedge pclk);
        logic_supply_low <= 1'h0;
        repeat (4) @(posedge pclk);
        check({pors == n + 1, fault_presence}, 2'h3);
        activate(1'h0);
        for (int i = 0; i < 4; i++)
        begin
            {divider_select_hi, divider_select_lo} <= 2'(i ^ (i >> 1));
            repeat (200) @(posedge pclk);
            toggles = 0;
            repeat (240) @(posedge pclk);
            n = 10 << i;
            check(toggles > n - 3 && toggles < n + 3, 1'h1);
        end
        i_host.stop();
        deact(1'h1);
        $display("test normal session done");
        // Faults in session: overheat, overload, pump, removal
        card_detect_n <= 1'h0;
        for (int f = 0; f < 4; f++)
        begin
            activate(f == 0);
            vcc_overcurrent <= (f == 1);
            repeat (2) @(posedge pclk);
            vcc_overcurrent <= 1'h0;
            repeat (6) @(posedge pclk);
            check(fault_presence, 1'h1);
            overheat <= (f == 0);
            vcc_overcurrent <= (f == 1);
            pump_fault <= (f == 2);
            card_detect <= (f != 3);
            card_detect_n <= (f == 3);
            repeat (8) @(posedge pclk);
            i_host.stop();
            overheat <= 1'h0;
            vcc_overcurrent <= 1'h0;
            pump_fault <= 1'h0;
            check(fault_presence, 1'h0);
            deact(f != 3);
            n = (f == 0) ? 16 : (f == 1) ? 1 : (f == 2) ? 8 : 2;
            apb(1'h0, card_seq_pkg::REG_FAULT, 32'h0);
            check(rd, n);
            apb(1'h1, card_seq_pkg::REG_FAULT, n);
            apb(1'h0, card_seq_pkg::REG_FAULT, 32'h0);
            check(rd, 32'h0);
            $display("test fault %0d done", f);
        end
        wrap_up();
    end
endmodule
